// File: shared/dsc_params.svh
// Timing constants and field positions for the strobe memory controller
// How it works
// - Fourteen-bit cell address goes out as two seven-bit halves on shared lines.
// - Row strobe falls first latching row half, then column strobe latches column half.
// - Column half and column strobe may follow once row hold time is met.
// - Write strobe before column strobe: data referenced to column strobe edge.
// - Delayed write: data captured on write strobe falling edge, timed to it.
// - Read keeps write strobe high while column strobe is low.
// - After power-up, run eight refresh cycles before normal use.
// - Refresh all 128 rows within every 2 millisecond interval, row-only cycles.
// - Page mode holds row strobe low and cycles column strobe per column.
`ifndef DSC_PARAMS_SVH
`define DSC_PARAMS_SVH
`define DSC_CLK_NS          40
`define DSC_ROW_HOLD_NS     35
`define DSC_RCD_MAX_NS      85
`define DSC_CAS_ACCESS_NS   165
`define DSC_RAS_ACCESS_NS   250
`define DSC_RAS_PULSE_NS    250
`define DSC_RAS_PRECH_NS    150
`define DSC_CAS_PULSE_NS    165
`define DSC_CAS_PRECH_NS    100
`define DSC_CWD_NS          90
`define DSC_RWD_NS          175
`define DSC_WP_NS           75
`define DSC_REFRESH_MS      2
`define DSC_ROWS            128
`define DSC_INIT_CYCLES     8
`define DSC_CEIL(ns)        (((ns) + `DSC_CLK_NS - 1) / `DSC_CLK_NS)
`define DSC_ROW_HOLD_CYC    `DSC_CEIL(`DSC_ROW_HOLD_NS)
`define DSC_CAS_ACC_CYC     (`DSC_CEIL(`DSC_CAS_ACCESS_NS) + 1)
`define DSC_RAS_ACC_CYC     (`DSC_CEIL(`DSC_RAS_ACCESS_NS) + 1)
`define DSC_RAS_PULSE_CYC   `DSC_CEIL(`DSC_RAS_PULSE_NS)
`define DSC_RAS_PRECH_CYC   `DSC_CEIL(`DSC_RAS_PRECH_NS)
`define DSC_CAS_PULSE_CYC   `DSC_CEIL(`DSC_CAS_PULSE_NS)
`define DSC_CAS_PRECH_CYC   `DSC_CEIL(`DSC_CAS_PRECH_NS)
`define DSC_CWD_CYC         `DSC_CEIL(`DSC_CWD_NS)
`define DSC_RWD_CYC         `DSC_CEIL(`DSC_RWD_NS)
`define DSC_WP_CYC          `DSC_CEIL(`DSC_WP_NS)
// Longest time rounds down: row period = 2 ms / 128 rows
`define DSC_REFRESH_PERIOD  ((`DSC_REFRESH_MS * 1000000) / `DSC_ROWS / `DSC_CLK_NS)
`define DSC_ROW_MSB         13
`define DSC_ROW_LSB         7
`define DSC_COL_MSB         6
`define DSC_COL_LSB         0
`endif

// File: shared/dsc_pkg.sv
// Types shared by the strobe memory controller
package dsc_pkg;
  typedef enum logic [1:0] {
    DSC_OP_READ,
    DSC_OP_WRITE,
    DSC_OP_RMW,
    DSC_OP_DWRITE
  } dsc_op_t;

  typedef struct packed {
    dsc_op_t     op;
    logic [13:0] addr;
    logic        wdata;
    logic        page;
  } dsc_req_t;

  typedef struct packed {
    logic       ras_n;
    logic       cas_n;
    logic       write_n;
    logic [6:0] addr;
    logic       din;
  } dsc_pins_t;
endpackage : dsc_pkg

// File: logic/dsc_refresh_timer.sv
// Refresh interval timer and row counter
`timescale 1ns/10ps
`include "dsc_params.svh"
module dsc_refresh_timer
  import dsc_pkg::*;
#(
  parameter int unsigned PERIOD = `DSC_REFRESH_PERIOD
)(
  input  wire logic       i_clk_sys,
  input  wire logic       i_reset,
  input  wire logic       i_done,
  output logic            o_due,
  output logic [6:0]      o_row
);
  logic [15:0] count;
  logic [15:0] next_count;
  logic        next_due;
  logic [6:0]  next_row;

  // Request is sticky; a new tick wins over the done pulse
  always_comb
  begin
    next_count = count + 16'h0001;
    next_due   = o_due;
    next_row   = o_row;
    if (i_done)
    begin
      next_due = 1'b0;
      next_row = o_row + 7'h01;
    end
    if (count == 16'(PERIOD - 1))
    begin
      next_count = 16'h0000;
      next_due   = 1'b1;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_reset)
  begin
    if (i_reset)
    begin
      count <= 16'h0000;
      o_due <= 1'b0;
      o_row <= 7'h00;
    end
    else
    begin
      count <= next_count;
      o_due <= next_due;
      o_row <= next_row;
    end
  end
endmodule : dsc_refresh_timer

// File: logic/dsc_ctrl.sv
// Strobe sequencer for a 16K x 1 multiplexed-address dynamic memory
`timescale 1ns/10ps
`include "dsc_params.svh"
module dsc_ctrl
  import dsc_pkg::*;
#(
  parameter int unsigned REFRESH_PERIOD = `DSC_REFRESH_PERIOD
)(
  input  wire logic      i_clk_sys,
  input  wire logic      i_reset,
  input  wire logic      i_req_valid,
  input  wire dsc_req_t  i_req,
  output logic           o_req_ready,
  output logic           o_rdata_valid,
  output logic           o_rdata,
  output logic           o_init_done,
  output dsc_pins_t      o_pins,
  input  wire logic      i_dout
);
  typedef enum logic [3:0] {
    DSC_ST_INIT_PRE,
    DSC_ST_IDLE,
    DSC_ST_ROW,
    DSC_ST_COL,
    DSC_ST_ACCESS,
    DSC_ST_LATE_WR,
    DSC_ST_CAS_END,
    DSC_ST_RAS_END,
    DSC_ST_PRECH,
    DSC_ST_REF
  } dsc_state_t;

  dsc_state_t state;
  dsc_state_t next_state;
  logic [3:0] cnt;
  logic [3:0] next_cnt;
  logic [3:0] init_cnt;
  logic [3:0] next_init_cnt;
  dsc_req_t   cur;
  dsc_req_t   next_cur;
  dsc_pins_t  next_pins;
  logic       next_ready;
  logic       next_rvalid;
  logic       next_rdata;
  logic       next_init_done;
  logic       ref_cycle;
  logic       next_ref_cycle;
  logic       ref_done;
  logic       ref_due;
  logic [6:0] ref_row;
  logic       dout_meta;
  logic       dout_sync;

  // Device output is a pin from outside the clock domain
  always_ff @(posedge i_clk_sys or posedge i_reset)
  begin
    if (i_reset)
    begin
      dout_meta <= 1'b0;
      dout_sync <= 1'b0;
    end
    else
    begin
      dout_meta <= i_dout;
      dout_sync <= dout_meta;
    end
  end

  dsc_refresh_timer #(
    .PERIOD (REFRESH_PERIOD)
  ) u_refresh (
    .i_clk_sys (i_clk_sys),
    .i_reset   (i_reset),
    .i_done    (ref_done),
    .o_due     (ref_due),
    .o_row     (ref_row)
  );

  // Sequencer: every strobe edge is one state step
  always_comb
  begin
    next_state     = state;
    next_cnt       = (cnt == 4'h0) ? 4'h0 : cnt - 4'h1;
    next_init_cnt  = init_cnt;
    next_cur       = cur;
    next_pins      = o_pins;
    next_ready     = 1'b0;
    next_rvalid    = 1'b0;
    next_rdata     = o_rdata;
    next_init_done = o_init_done;
    next_ref_cycle = ref_cycle;
    ref_done       = 1'b0;
    case (state)
      DSC_ST_INIT_PRE:
      begin
        // Power-up needs refresh cycles before real traffic
        if (cnt == 4'h0)
        begin
          next_state          = DSC_ST_REF;
          next_pins.addr      = init_cnt[2:0] == 3'h0 ? 7'h00 : ref_row;
          next_pins.ras_n     = 1'b0;
          next_cnt            = 4'(`DSC_RAS_PULSE_CYC - 1);
        end
      end
      DSC_ST_IDLE:
      begin
        // A shown ready is honoured; sticky refresh waits until that access has finished
        if (i_req_valid && o_req_ready)
        begin
          next_cur            = i_req;
          next_state          = DSC_ST_ROW;
          next_pins.addr      = i_req.addr[`DSC_ROW_MSB:`DSC_ROW_LSB];
          next_pins.ras_n     = 1'b0;
          next_cnt            = 4'(`DSC_ROW_HOLD_CYC - 1);
        end
        else if (ref_due)
        begin
          next_state          = DSC_ST_REF;
          next_pins.addr      = ref_row;
          next_pins.ras_n     = 1'b0;
          next_cnt            = 4'(`DSC_RAS_PULSE_CYC - 1);
        end
        else
        begin
          next_ready = ~ref_due;
        end
      end
      DSC_ST_ROW:
      begin
        // Column half swaps in once the row hold time has passed
        if (cnt == 4'h0)
        begin
          next_state       = DSC_ST_COL;
          next_pins.addr   = cur.addr[`DSC_COL_MSB:`DSC_COL_LSB];
          next_pins.din    = cur.wdata;
          next_pins.write_n = ~(cur.op == DSC_OP_WRITE);
        end
      end
      DSC_ST_COL:
      begin
        // Falls late; access is then counted from the column edge
        next_pins.cas_n = 1'b0;
        next_state      = DSC_ST_ACCESS;
        next_cnt        = 4'((cur.op == DSC_OP_WRITE) ?
                             `DSC_CAS_PULSE_CYC : `DSC_CAS_ACC_CYC) - 4'h1;
      end
      DSC_ST_ACCESS:
      begin
        // Write strobe stays high over the read window
        if (cnt == 4'h0)
        begin
          if (cur.op == DSC_OP_READ || cur.op == DSC_OP_RMW)
          begin
            next_rvalid = 1'b1;
            next_rdata  = dout_sync;
          end
          if (cur.op == DSC_OP_WRITE || cur.op == DSC_OP_READ)
          begin
            next_state = DSC_ST_CAS_END;
            next_cnt   = 4'h0;
          end
          else
          begin
            // Late write edge strobes the data in
            next_pins.write_n = 1'b0;
            next_state        = DSC_ST_LATE_WR;
            next_cnt          = 4'(`DSC_WP_CYC - 1);
          end
        end
      end
      DSC_ST_LATE_WR:
      begin
        if (cnt == 4'h0)
        begin
          next_state = DSC_ST_CAS_END;
        end
      end
      DSC_ST_CAS_END:
      begin
        // Column rise ends the cycle; write strobe returns too
        next_pins.cas_n   = 1'b1;
        next_pins.write_n = 1'b1;
        if (cur.page && i_req_valid && i_req.addr[`DSC_ROW_MSB:`DSC_ROW_LSB]
            == cur.addr[`DSC_ROW_MSB:`DSC_ROW_LSB] && !ref_due)
        begin
          // Same row: keep row strobe low, next column only
          next_cur   = i_req;
          next_state = DSC_ST_ROW;
          next_cnt   = 4'(`DSC_CAS_PRECH_CYC - 1);
          next_ready = 1'b0;
        end
        else
        begin
          next_state = DSC_ST_RAS_END;
        end
      end
      DSC_ST_RAS_END:
      begin
        next_pins.ras_n = 1'b1;
        next_state      = DSC_ST_PRECH;
        next_cnt        = 4'(`DSC_RAS_PRECH_CYC - 1);
      end
      DSC_ST_PRECH:
      begin
        if (cnt == 4'h0)
        begin
          next_state = o_init_done ? DSC_ST_IDLE : DSC_ST_INIT_PRE;
        end
      end
      DSC_ST_REF:
      begin
        // Row-only cycle; column strobe untouched
        if (cnt == 4'h0)
        begin
          next_pins.ras_n = 1'b1;
          ref_done        = 1'b1;
          next_state      = DSC_ST_PRECH;
          next_cnt        = 4'(`DSC_RAS_PRECH_CYC - 1);
          if (!o_init_done)
          begin
            next_init_cnt = init_cnt + 4'h1;
            if (init_cnt == 4'(`DSC_INIT_CYCLES - 1))
            begin
              next_init_done = 1'b1;
            end
          end
        end
      end
      default:
      begin
        next_state = DSC_ST_IDLE;
      end
    endcase
    next_ref_cycle = (next_state == DSC_ST_REF);
  end

  // Registers only; strobe pins idle high so no device runs a cycle
  always_ff @(posedge i_clk_sys or posedge i_reset)
  begin
    if (i_reset)
    begin
      state         <= DSC_ST_INIT_PRE;
      cnt           <= 4'h0;
      init_cnt      <= 4'h0;
      cur           <= '0;
      o_pins        <= '{ras_n: 1'b1, cas_n: 1'b1, write_n: 1'b1,
                         addr: 7'h00, din: 1'b0};
      o_req_ready   <= 1'b0;
      o_rdata_valid <= 1'b0;
      o_rdata       <= 1'b0;
      o_init_done   <= 1'b0;
      ref_cycle     <= 1'b0;
    end
    else
    begin
      state         <= next_state;
      cnt           <= next_cnt;
      init_cnt      <= next_init_cnt;
      cur           <= next_cur;
      o_pins        <= next_pins;
      o_req_ready   <= next_ready;
      o_rdata_valid <= next_rvalid;
      o_rdata       <= next_rdata;
      o_init_done   <= next_init_done;
      ref_cycle     <= next_ref_cycle;
    end
  end
endmodule : dsc_ctrl

// File: test/dsc_ctrl_checker.sv
// Port assertions for the strobe memory controller
`timescale 1ns/10ps
module dsc_ctrl_checker
  import dsc_pkg::*;
#(
  parameter int unsigned REFRESH_PERIOD = 390
)(
  input wire logic      i_clk_sys,
  input wire logic      i_reset,
  input wire logic      i_req_valid,
  input wire dsc_req_t  i_req,
  input wire logic      o_req_ready,
  input wire logic      o_rdata_valid,
  input wire logic      o_rdata,
  input wire logic      o_init_done,
  input wire dsc_pins_t o_pins,
  input wire logic      i_dout
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);
  // Request accepted at this edge
  wire take = i_req_valid && o_req_ready;

  cas_needs_row_a: assert property (!o_pins.cas_n |-> !o_pins.ras_n)
    else $error("column strobe low without row strobe");
  row_first_a: assert property ($fell(o_pins.cas_n) |-> !$past(o_pins.ras_n))
    else $error("column strobe fell before row strobe");
  col_addr_hold_a: assert property
    (!o_pins.cas_n && !$past(o_pins.cas_n) |-> $stable(o_pins.addr))
    else $error("address moved while column strobe low");
  take_row_a: assert property (take |=> !o_pins.ras_n)
    else $error("row strobe not lowered after take");
  read_answer_a: assert property
    (take && i_req.op == DSC_OP_READ |-> ##[7:11] o_rdata_valid)
    else $error("read data not returned in time");
  write_quiet_a: assert property
    (take && i_req.op == DSC_OP_WRITE |=> !o_rdata_valid [*8])
    else $error("read pulse during plain write");
  init_ready_a: assert property (o_req_ready |-> o_init_done)
    else $error("ready before power-up refresh done");
  cas_width_a: assert property ($fell(o_pins.cas_n) |-> !o_pins.cas_n [*5])
    else $error("column strobe pulse too short");
  ras_prech_a: assert property ($rose(o_pins.ras_n) |-> o_pins.ras_n [*4])
    else $error("row precharge too short");
  din_hold_a: assert property
    (!o_pins.write_n && !$past(o_pins.write_n) |-> $stable(o_pins.din))
    else $error("write data moved during write strobe");

  // Main traffic kinds seen at least once
  cover property (o_rdata_valid);
  cover property ($fell(o_pins.write_n) && !o_pins.cas_n);
  cover property ($rose(o_pins.ras_n) && $past(o_pins.cas_n, 4));
endmodule : dsc_ctrl_checker

bind dsc_ctrl dsc_ctrl_checker #(.REFRESH_PERIOD(REFRESH_PERIOD)) u_chk (
  .i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_req_valid(i_req_valid),
  .i_req(i_req), .o_req_ready(o_req_ready), .o_rdata_valid(o_rdata_valid),
  .o_rdata(o_rdata), .o_init_done(o_init_done), .o_pins(o_pins),
  .i_dout(i_dout));

// File: test/dsc_mem_model.sv
// Behavioural 16K x 1 strobe memory driven by the controller pins
`timescale 1ns/10ps
module dsc_mem_model
  import dsc_pkg::*;
#(
  parameter int ACC_NS = 100
)(
  input wire dsc_pins_t i_pins,
  output logic          o_dout
);
  logic       mem [0:16383];
  logic [6:0] row;
  logic [6:0] col;
  logic       drive;
  logic       val;
  logic       junk;

  initial
  begin
    drive = 1'b0;
    val = 1'b0;
    junk = 1'b0;
  end
  // Floating output wanders so stale values never look valid
  always #20 junk = ~junk;
  assign o_dout = drive ? val : junk;

  // Row half latched on row strobe fall
  always @(negedge i_pins.ras_n)
    row = i_pins.addr;
  always @(posedge i_pins.cas_n)
    drive = 1'b0;
  // Column latch; without row strobe stays in standby
  always @(negedge i_pins.cas_n)
  begin
    if (!i_pins.ras_n)
    begin
      col = i_pins.addr;
      if (!i_pins.write_n)
        mem[{row, col}] = i_pins.din;
      else
      begin
        #(ACC_NS);
        val = mem[{row, col}];
        if (!i_pins.cas_n)
          drive = 1'b1;
      end
    end
  end
  // Delayed write strobes data on the write edge
  always @(negedge i_pins.write_n)
    if (!i_pins.ras_n && !i_pins.cas_n)
      mem[{row, col}] = i_pins.din;
endmodule : dsc_mem_model

// File: test/dsc_ctrl_bench.sv
// Random self-checking bench for the strobe memory controller
`timescale 1ns/10ps
module dsc_ctrl_bench
  import dsc_pkg::*;
;
  logic        clk, rst, valid, ready, rvalid, rdata, idone, dout;
  dsc_req_t    req;
  dsc_pins_t   pins;
  int          fails, checked, inits;
  logic [31:0] seed;
  logic [13:0] addrs [8];
  logic        mem [logic [13:0]];

  dsc_ctrl #(.REFRESH_PERIOD(50)) uut (.i_clk_sys(clk), .i_reset(rst),
    .i_req_valid(valid), .i_req(req), .o_req_ready(ready),
    .o_rdata_valid(rvalid), .o_rdata(rdata), .o_init_done(idone),
    .o_pins(pins), .i_dout(dout));
  dsc_mem_model #(.ACC_NS(100)) u_mem (.i_pins(pins), .o_dout(dout));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  // Last bit written to a cell is what a read must see
  function automatic logic expect_bit(input logic [13:0] a);
    return mem[a];
  endfunction : expect_bit

  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic final_report;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : final_report

  // Entered at a falling edge; valid held until ready seen
  task automatic do_op(input dsc_op_t op, input logic [13:0] a,
                       input logic d);
    int n;
    n = 0;
    // One idle edge so valid is never driven twice in a time step
    @(negedge clk);
    req = '{op: op, addr: a, wdata: d, page: 1'b0};
    valid = 1'b1;
    while (ready !== 1'b1 && n < 200)
    begin
      @(negedge clk);
      n++;
    end
    check("req taken", {15'h0, ready}, 16'h0001);
    @(negedge clk);
    valid = 1'b0;
    if (op == DSC_OP_READ || op == DSC_OP_RMW)
    begin
      n = 0;
      while (rvalid !== 1'b1 && n < 20)
      begin
        @(negedge clk);
        n++;
      end
      check("read valid", {15'h0, rvalid}, 16'h0001);
      check("read bit", {15'h0, rdata}, {15'h0, expect_bit(a)});
    end
    if (op != DSC_OP_READ)
      mem[a] = d;
  endtask : do_op

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Row strobes issued before init completes
  always @(negedge pins.ras_n)
    if (idone === 1'b0)
      inits++;

  initial
  begin
    #(40 * 6000);
    fails++;
    final_report();
  end

  initial
  begin
    int n;
    fails = 0;
    checked = 0;
    inits = 0;
    rst = 1'b1;
    valid = 1'b0;
    req = '0;
    seed = 32'hb7ec566c;
    repeat (10) @(negedge clk);
    check("idle strobes", {13'h0, pins.ras_n, pins.cas_n, pins.write_n},
          16'h0007);
    rst = 1'b0;
    n = 0;
    while (idone !== 1'b1 && n < 400)
    begin
      @(negedge clk);
      n++;
    end
    check("init cycles", inits[15:0], 16'h0008);
    // Corner addresses first, then a random pool
    addrs[0] = 14'h0000;
    addrs[1] = 14'h3fff;
    for (int i = 2; i < 8; i++)
    begin
      seed = lfsr(seed);
      addrs[i] = seed[13:0];
    end
    for (int i = 0; i < 8; i++)
    begin
      seed = lfsr(seed);
      do_op(DSC_OP_WRITE, addrs[i], seed[7]);
    end
    for (int i = 0; i < 8; i++)
      do_op(DSC_OP_READ, addrs[i], 1'b0);
    // All four operation codes mixed over the pool
    for (int i = 0; i < 60; i++)
    begin
      seed = lfsr(seed);
      do_op(dsc_op_t'(seed[1:0]), addrs[seed[4:2]], seed[5]);
    end
    for (int i = 0; i < 8; i++)
      do_op(DSC_OP_READ, addrs[i], 1'b0);
    final_report();
  end
endmodule : dsc_ctrl_bench
